// >>> design/iwd_decoder.sv
`timescale 1ns/10ps
// Overview of operation
// - Words are 16 bits; four take two
// - Split each word into opcode and operands
// - Every instruction falls in one group
// - Destination bit picks working_register or file
// - Bit ops carry file address and bit
// - Literals give constant and pointer select
// - Control ops give address, mode, table mode
// - Second word tagged by four top ones
// - Lone second word executes as no-operation
// - Taken test or jump adds one cycle
// - Double-word instructions take two cycles
// - Instruction cycle is four oscillator periods
// - Bank bit: access RAM or selected bank
// - Fast bit uses shadow registers
// - Four table pointer modes
// - Bit number is three bits wide
module iwd_decoder (
  input wire logic I_REF_CLK,                 // Oscillator clock
  input wire logic I_NRST,                    // Async reset, active low
  input wire logic I_WORD_VALID,              // Program word present
  input wire logic [15:0] I_WORD,             // Program word
  input wire logic I_SKIP_TAKEN,              // Last test true: flush next
  output logic [1:0] O_Q_PHASE,               // Oscillator phase in cycle
  output logic O_CYCLE_START,                 // Pulse at cycle start
  output logic O_VALID,                       // Decoded instruction ready
  output logic O_NOP,                         // Execute as no-operation
  output iwd_pkg::iwd_class_e O_CLASS,        // Instruction group
  output logic [7:0] O_OPCODE,                // Opcode bits of first word
  output iwd_pkg::iwd_fields_s O_FIELDS,      // Operand fields
  output logic O_DOUBLE,                      // Two-word instruction
  output logic O_SKIP_TYPE,                   // Conditional skip or branch
  output logic [1:0] O_CYCLES                 // Base execution cycles
);

  typedef enum logic {
    IWD_ST_FIRST,
    IWD_ST_SECOND
  } iwd_state_e;

  // Phase counter and boundary strobe
  logic [1:0] q_reg, q_next;
  logic start_reg, start_next;
  logic boundary; // Last phase of a cycle

  assign boundary = (q_reg == iwd_pkg::IWD_Q_LAST);

  // Next phase: four periods per instruction cycle
  always_comb begin
    q_next = q_reg + 2'h1;
    start_next = boundary;
  end

  // Phase registers
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      q_reg <= iwd_pkg::IWD_Q_FIRST;
      start_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
      start_reg <= start_next;
    end
  end

  // Single-word decode, pure combinational
  iwd_pkg::iwd_class_e cls;       // Group of this word
  iwd_pkg::iwd_fields_s fld;      // Fields of this word
  logic is_first2;                // Opens a double-word
  logic is_skip;                  // Conditional instruction
  logic is_jump;                  // Always alters program counter
  logic is_tag;                   // Second-word tag seen
  logic [3:0] top;                // Top nibble
  logic [7:0] ub;                 // Upper byte
  logic [7:0] lb;                 // Lower byte

  always_comb begin
    top = I_WORD[15:12];
    ub = I_WORD[15:8];
    lb = I_WORD[7:0];
    fld = '0;
    is_first2 = 1'b0;
    is_skip = 1'b0;
    is_jump = 1'b0;
    is_tag = (top == iwd_pkg::IWD_SECOND_TAG);
    cls = iwd_pkg::IWD_BYTE;
    // Common byte/bit field layout
    fld.file_addr = {4'h0, lb};
    fld.bank_from_sel = I_WORD[8];
    fld.dest_file = I_WORD[9];
    fld.bit_num = I_WORD[11:9];
    fld.tbl_mode = iwd_pkg::IWD_TBL_KEEP;
    if (is_tag) begin
      // Stray second word: no operation
      cls = iwd_pkg::IWD_CONTROL;
      fld = '0;
    end else if (ub == iwd_pkg::IWD_UB_CTRL) begin
      // Control page: table moves, returns, misc
      cls = iwd_pkg::IWD_CONTROL;
      fld = '0;
      if (lb >= iwd_pkg::IWD_LB_TBL_MIN && lb <= iwd_pkg::IWD_LB_TBL_MAX) begin
        fld.tbl_mode = iwd_pkg::iwd_tbl_e'(I_WORD[1:0]);
      end
      if (I_WORD[7:1] == iwd_pkg::IWD_LB_RET ||
          I_WORD[7:1] == (iwd_pkg::IWD_LB_RET + 7'h01)) begin
        fld.fast = I_WORD[0];
        is_jump = 1'b1;
      end
    end else if (ub == iwd_pkg::IWD_UB_BANK ||
        (ub >= iwd_pkg::IWD_UB_LIT_MIN && ub <= iwd_pkg::IWD_UB_LIT_MAX)) begin
      // Immediate forms with an 8-bit constant
      cls = iwd_pkg::IWD_LITERAL;
      fld = '0;
      fld.literal = {12'h000, lb};
    end else if (top == iwd_pkg::IWD_OP_MISC) begin
      cls = iwd_pkg::IWD_BYTE;
    end else if (top >= iwd_pkg::IWD_OP_BIT_LO &&
        top <= iwd_pkg::IWD_OP_BIT_HI) begin
      cls = iwd_pkg::IWD_BIT;
      fld.dest_file = 1'b0;
      is_skip = (top == iwd_pkg::IWD_OP_SKIPBIT_S) ||
                (top == iwd_pkg::IWD_OP_SKIPBIT_C);
    end else if (top == iwd_pkg::IWD_OP_MOVE) begin
      // Move between 12-bit file addresses
      cls = iwd_pkg::IWD_BYTE;
      fld = '0;
      fld.file_addr = I_WORD[11:0];
      is_first2 = 1'b1;
    end else if (top == iwd_pkg::IWD_OP_REL) begin
      cls = iwd_pkg::IWD_CONTROL;
      fld = '0;
      fld.literal = {9'h000, I_WORD[10:0]};
      is_jump = 1'b1;
    end else if (top == iwd_pkg::IWD_OP_EXT) begin
      cls = iwd_pkg::IWD_CONTROL;
      fld = '0;
      fld.literal = {12'h000, lb};
      if (ub == iwd_pkg::IWD_UB_CALL0 || ub == iwd_pkg::IWD_UB_CALL1) begin
        fld.fast = I_WORD[8];
        is_first2 = 1'b1;
      end else if (ub == iwd_pkg::IWD_UB_JUMP) begin
        is_first2 = 1'b1;
      end else if (ub == iwd_pkg::IWD_UB_PTRLD) begin
        cls = iwd_pkg::IWD_LITERAL;
        fld.ptr_sel = I_WORD[5:4];
        fld.literal = {16'h0000, I_WORD[3:0]};
        is_first2 = 1'b1;
      end else if (I_WORD[15:11] == iwd_pkg::IWD_CBR_TAG) begin
        is_skip = 1'b1; // Conditional relative branch
      end else begin
        is_jump = 1'b1; // Unconditional relative form
      end
    end else begin
      // Remaining byte-oriented pages 1..6
      cls = iwd_pkg::IWD_BYTE;
      is_skip = (I_WORD[15:9] >= iwd_pkg::IWD_SK_CMP_HI - 7'h02 &&
                 I_WORD[15:9] <= iwd_pkg::IWD_SK_CMP_HI) ||
                (I_WORD[15:10] == iwd_pkg::IWD_SK_DECZ) ||
                (I_WORD[15:10] == iwd_pkg::IWD_SK_INCZ) ||
                (I_WORD[15:10] == iwd_pkg::IWD_SK_INNZ) ||
                (I_WORD[15:10] == iwd_pkg::IWD_SK_DCNZ);
    end
  end

  // Sequencer and output state
  iwd_state_e st_reg, st_next;
  logic flush_reg, flush_next;       // Next word to be squashed
  logic valid_reg, valid_next;
  logic nop_reg, nop_next;
  iwd_pkg::iwd_class_e cls_reg, cls_next;
  logic [7:0] opc_reg, opc_next;
  iwd_pkg::iwd_fields_s fld_reg, fld_next;
  logic dbl_reg, dbl_next;
  logic skip_reg, skip_next;
  logic [1:0] cyc_reg, cyc_next;

  // Next-state: dispatch at each cycle boundary
  always_comb begin
    st_next = st_reg;
    flush_next = flush_reg;
    valid_next = 1'b0;
    nop_next = nop_reg;
    cls_next = cls_reg;
    opc_next = opc_reg;
    fld_next = fld_reg;
    dbl_next = dbl_reg;
    skip_next = skip_reg;
    cyc_next = cyc_reg;
    if (boundary) begin
      if (I_SKIP_TAKEN) begin
        flush_next = 1'b1;
      end
      if (I_WORD_VALID) begin
        case (st_reg)
          IWD_ST_FIRST: begin
            flush_next = I_SKIP_TAKEN;
            if (flush_reg) begin
              // Squashed word: extra no-operation cycle
              valid_next = 1'b1;
              nop_next = 1'b1;
              cls_next = iwd_pkg::IWD_CONTROL;
              opc_next = iwd_pkg::IWD_WORD_NOP[15:8];
              fld_next = '0;
              dbl_next = 1'b0;
              skip_next = 1'b0;
              cyc_next = iwd_pkg::IWD_CYC_ONE;
            end else if (is_first2) begin
              // Hold first word, await operand word
              st_next = IWD_ST_SECOND;
              cls_next = cls;
              opc_next = I_WORD[15:8];
              fld_next = fld;
              // A squash raised here still hits the word after the pair
            end else begin
              valid_next = 1'b1;
              nop_next = is_tag;
              cls_next = cls;
              opc_next = I_WORD[15:8];
              fld_next = fld;
              dbl_next = 1'b0;
              skip_next = is_skip;
              cyc_next = is_jump ? iwd_pkg::IWD_CYC_TWO :
                                   iwd_pkg::IWD_CYC_ONE;
            end
          end
          IWD_ST_SECOND: begin
            // Merge operand word into held fields
            st_next = IWD_ST_FIRST;
            valid_next = 1'b1;
            nop_next = 1'b0;
            dbl_next = 1'b1;
            skip_next = 1'b0;
            cyc_next = iwd_pkg::IWD_CYC_TWO;
            if (opc_reg[7:4] == iwd_pkg::IWD_OP_MOVE) begin
              fld_next.file_dst = I_WORD[11:0];
            end else if (opc_reg == iwd_pkg::IWD_UB_PTRLD) begin
              fld_next.literal = {8'h00, fld_reg.literal[3:0],
                                  I_WORD[7:0]};
            end else begin
              fld_next.literal = {I_WORD[11:0],
                                  fld_reg.literal[7:0]};
            end
          end
          default: begin
            st_next = IWD_ST_FIRST;
          end
        endcase
      end
    end
  end

  // Sequencer registers
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      st_reg <= IWD_ST_FIRST;
      flush_reg <= 1'b0;
      valid_reg <= 1'b0;
      nop_reg <= 1'b0;
      cls_reg <= iwd_pkg::IWD_BYTE;
      opc_reg <= 8'h00;
      fld_reg <= '0;
      dbl_reg <= 1'b0;
      skip_reg <= 1'b0;
      cyc_reg <= iwd_pkg::IWD_CYC_ONE;
    end else begin
      st_reg <= st_next;
      flush_reg <= flush_next;
      valid_reg <= valid_next;
      nop_reg <= nop_next;
      cls_reg <= cls_next;
      opc_reg <= opc_next;
      fld_reg <= fld_next;
      dbl_reg <= dbl_next;
      skip_reg <= skip_next;
      cyc_reg <= cyc_next;
    end
  end

  // Outputs straight from registers
  assign O_Q_PHASE = q_reg;
  assign O_CYCLE_START = start_reg;
  assign O_VALID = valid_reg;
  assign O_NOP = nop_reg;
  assign O_CLASS = cls_reg;
  assign O_OPCODE = opc_reg;
  assign O_FIELDS = fld_reg;
  assign O_DOUBLE = dbl_reg;
  assign O_SKIP_TYPE = skip_reg;
  assign O_CYCLES = cyc_reg;

endmodule : iwd_decoder

// >>> design/iwd_pkg.sv
package iwd_pkg;
  // Instruction groups
  typedef enum logic [1:0] {
    IWD_BYTE,
    IWD_BIT,
    IWD_LITERAL,
    IWD_CONTROL
  } iwd_class_e;

  // Program memory pointer behaviour for table moves
  typedef enum logic [1:0] {
    IWD_TBL_KEEP,
    IWD_TBL_POST_INC,
    IWD_TBL_POST_DEC,
    IWD_TBL_PRE_INC
  } iwd_tbl_e;

  // Decoded operand fields
  typedef struct packed {
    logic dest_file;       // 1: result back to file register
    logic bank_from_sel;   // 1: bank from ram_bank_selector
    logic [2:0] bit_num;   // Bit position 0..7
    logic [11:0] file_addr; // File address (8 or 12 bits)
    logic [11:0] file_dst; // Destination address of move
    logic [19:0] literal;  // Immediate constant or program address
    logic [1:0] ptr_sel;   // Indirect pointer register select
    logic fast;            // Shadow register save/restore
    iwd_tbl_e tbl_mode;    // Table pointer mode
  } iwd_fields_s;

  localparam int unsigned IWD_PHASES = 4;
  localparam logic [1:0] IWD_Q_LAST = 2'h3;
  localparam logic [1:0] IWD_Q_FIRST = 2'h0;
  localparam logic [1:0] IWD_CYC_ONE = 2'h1;
  localparam logic [1:0] IWD_CYC_TWO = 2'h2;
  localparam logic [3:0] IWD_SECOND_TAG = 4'hf;
  // Top nibble codes
  localparam logic [3:0] IWD_OP_MISC = 4'h0;
  localparam logic [3:0] IWD_OP_BIT_LO = 4'h7;
  localparam logic [3:0] IWD_OP_BIT_HI = 4'hb;
  localparam logic [3:0] IWD_OP_MOVE = 4'hc;
  localparam logic [3:0] IWD_OP_REL = 4'hd;
  localparam logic [3:0] IWD_OP_EXT = 4'he;
  localparam logic [3:0] IWD_OP_SKIPBIT_S = 4'ha;
  localparam logic [3:0] IWD_OP_SKIPBIT_C = 4'hb;
  // Upper byte codes
  localparam logic [7:0] IWD_UB_CTRL = 8'h00;
  localparam logic [7:0] IWD_UB_BANK = 8'h01;
  localparam logic [7:0] IWD_UB_CALL0 = 8'hec;
  localparam logic [7:0] IWD_UB_CALL1 = 8'hed;
  localparam logic [7:0] IWD_UB_PTRLD = 8'hee;
  localparam logic [7:0] IWD_UB_JUMP = 8'hef;
  localparam logic [7:0] IWD_UB_LIT_MIN = 8'h08;
  localparam logic [7:0] IWD_UB_LIT_MAX = 8'h0f;
  // Low byte codes inside the control page
  localparam logic [7:0] IWD_LB_TBL_MIN = 8'h08;
  localparam logic [7:0] IWD_LB_TBL_MAX = 8'h0f;
  localparam logic [6:0] IWD_LB_RET = 7'h08;
  // Skip patterns on bits 15:9, 15:10 and 15:11
  localparam logic [6:0] IWD_SK_CMP_HI = 7'h32;
  localparam logic [5:0] IWD_SK_DECZ = 6'h0b;
  localparam logic [5:0] IWD_SK_INCZ = 6'h0f;
  localparam logic [5:0] IWD_SK_INNZ = 6'h12;
  localparam logic [5:0] IWD_SK_DCNZ = 6'h13;
  localparam logic [4:0] IWD_CBR_TAG = 5'h1c;
  localparam logic [15:0] IWD_WORD_NOP = 16'h0000;
endpackage : iwd_pkg

// >>> design/dummy_never.sv
`timescale 1ns/10ps

// >>> verification/iwd_decoder_sva.sv
`timescale 1ns/10ps
// Timing and decode checks on the decoder's ports
module iwd_decoder_chk (
  input wire logic I_REF_CLK, // Oscillator clock
  input wire logic I_NRST, // Reset, active low
  input wire logic I_WORD_VALID, // Word present
  input wire logic [15:0] I_WORD, // Program word
  input wire logic I_SKIP_TAKEN, // Squash next word
  input wire logic [1:0] O_Q_PHASE, // Phase in cycle
  input wire logic O_CYCLE_START, // Cycle start pulse
  input wire logic O_VALID, // Decode published
  input wire logic O_NOP, // Runs as no-operation
  input wire iwd_pkg::iwd_class_e O_CLASS, // Group
  input wire logic [7:0] O_OPCODE, // Opcode byte
  input wire iwd_pkg::iwd_fields_s O_FIELDS, // Operands
  input wire logic O_DOUBLE, // Two-word instruction
  input wire logic O_SKIP_TYPE, // Skip or branch
  input wire logic [1:0] O_CYCLES // Base cycles
);
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_NRST);
  logic take; // Word taken at this edge
  logic opener; // Word opens a two-word pair
  logic calm; // Boundary with no pair or squash open
  assign take = (O_Q_PHASE == iwd_pkg::IWD_Q_LAST) && I_WORD_VALID;
  assign opener = (I_WORD[15:12] == iwd_pkg::IWD_OP_MOVE) ||
    (I_WORD[15:10] == 6'h3b);
  assign calm = (O_Q_PHASE == iwd_pkg::IWD_Q_LAST) && !I_SKIP_TAKEN &&
    !(I_WORD_VALID && opener);
  chk_cycle_len: assert property (
    $rose(O_CYCLE_START) |=> !O_CYCLE_START [*3] ##1 O_CYCLE_START)
    else $error("cycle start spacing wrong");
  chk_phase_wrap: assert property (
    O_Q_PHASE == iwd_pkg::IWD_Q_LAST |=>
    O_Q_PHASE == iwd_pkg::IWD_Q_FIRST && O_CYCLE_START)
    else $error("phase did not wrap to cycle start");
  chk_valid_start: assert property (
    O_VALID |-> O_CYCLE_START && O_Q_PHASE == iwd_pkg::IWD_Q_FIRST)
    else $error("decode outside cycle start");
  chk_single_answer: assert property (
    take && !opener |=> O_VALID)
    else $error("single word not answered");
  chk_pair_hold: assert property (
    calm ##4 (take && opener) |=> !O_VALID)
    else $error("first word published alone");
  chk_lone_nop: assert property (
    calm ##4 (take && I_WORD[15:12] == iwd_pkg::IWD_SECOND_TAG)
    |=> O_VALID && O_NOP)
    else $error("stray second word not a no-operation");
  chk_double_cycles: assert property (
    O_VALID && O_DOUBLE && !O_NOP |-> O_CYCLES == iwd_pkg::IWD_CYC_TWO)
    else $error("double word not two cycles");
  chk_jump_cycles: assert property (
    O_VALID && !O_NOP && O_OPCODE[7:4] == iwd_pkg::IWD_OP_REL
    |-> O_CYCLES == iwd_pkg::IWD_CYC_TWO)
    else $error("jump not two cycles");
  chk_plain_cycles: assert property (
    O_VALID && !O_NOP && !O_DOUBLE && O_CLASS == iwd_pkg::IWD_LITERAL
    |-> O_CYCLES == iwd_pkg::IWD_CYC_ONE)
    else $error("plain literal not one cycle");
  chk_bit_field: assert property (
    O_VALID && O_CLASS == iwd_pkg::IWD_BIT
    |-> O_FIELDS.bit_num == O_OPCODE[3:1])
    else $error("bit number field wrong");
  chk_dest_bank: assert property (
    O_VALID && !O_NOP && !O_DOUBLE && O_CLASS == iwd_pkg::IWD_BYTE |->
    O_FIELDS.dest_file == O_OPCODE[1] &&
    O_FIELDS.bank_from_sel == O_OPCODE[0])
    else $error("destination or bank bit wrong");
endmodule : iwd_decoder_chk

bind iwd_decoder iwd_decoder_chk iwd_decoder_chk_inst (
  .I_REF_CLK(I_REF_CLK),
  .I_NRST(I_NRST),
  .I_WORD_VALID(I_WORD_VALID),
  .I_WORD(I_WORD),
  .I_SKIP_TAKEN(I_SKIP_TAKEN),
  .O_Q_PHASE(O_Q_PHASE),
  .O_CYCLE_START(O_CYCLE_START),
  .O_VALID(O_VALID),
  .O_NOP(O_NOP),
  .O_CLASS(O_CLASS),
  .O_OPCODE(O_OPCODE),
  .O_FIELDS(O_FIELDS),
  .O_DOUBLE(O_DOUBLE),
  .O_SKIP_TYPE(O_SKIP_TYPE),
  .O_CYCLES(O_CYCLES)
);

// >>> verification/iwd_prog_mem.sv
`timescale 1ns/10ps
// Program memory: one word per instruction cycle, bus flips when idle
module iwd_prog_mem (
  input wire logic i_clk, // Oscillator clock
  input wire logic i_nrst, // Reset, active low
  input wire logic [1:0] i_q_phase, // Decoder phase
  input wire logic i_run, // Fetch enable
  output logic o_word_valid, // Word present
  output logic [15:0] o_word // Program word
);
  logic [15:0] mem [0:15]; // Program contents
  logic [3:0] pc_reg; // Fetch pointer
  logic fetch; // Word due at next boundary
  assign fetch = i_run && (i_q_phase == 2'h2);
  // Word stands over the boundary edge only, then is released
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_word_valid <= 1'b0;
      o_word <= 16'h0000;
      pc_reg <= 4'h0;
    end else begin
      o_word_valid <= fetch;
      o_word <= fetch ? mem[pc_reg] : ~o_word;
      if (!i_run) pc_reg <= 4'h0;
      else if (fetch) pc_reg <= pc_reg + 4'h1;
    end
  end
endmodule : iwd_prog_mem

// >>> verification/instruction_word_decode_timing_tb_top.sv
`timescale 1ns/10ps
`define IWD_CHK(got, exp, msg) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("wrong value at %0t: %s", $time, msg); \
  end \
end
module instruction_word_decode_timing_tb_top;
  // One captured decode
  typedef struct packed {
    logic nop;
    iwd_pkg::iwd_class_e cls;
    iwd_pkg::iwd_fields_s f;
    logic dbl;
    logic skt;
    logic [1:0] cyc;
    logic cs;
  } iwd_cap_s;
  logic clk = 1'b0; // Oscillator clock
  logic rst_n = 1'b0; // Reset, active low
  logic skip = 1'b0; // Squash request
  logic run = 1'b0; // Fetch enable
  logic wv; // Word present
  logic [15:0] word; // Program word
  logic [1:0] q_phase; // Phase
  logic cyc_start, vld, nop_o, dbl, skt; // Decoder flags
  iwd_pkg::iwd_class_e cls; // Group
  logic [7:0] opc; // Opcode byte
  iwd_pkg::iwd_fields_s fld; // Operands
  logic [1:0] cycles; // Base cycles
  int checks = 0;
  int bad_count = 0;
  int cyc_count = 0;
  iwd_cap_s cap [0:7];
  always #50 clk = ~clk;
  iwd_prog_mem iwd_prog_mem_inst (.i_clk(clk), .i_nrst(rst_n),
    .i_q_phase(q_phase), .i_run(run), .o_word_valid(wv), .o_word(word));
  iwd_decoder iwd_decoder_inst (.I_REF_CLK(clk), .I_NRST(rst_n),
    .I_WORD_VALID(wv), .I_WORD(word), .I_SKIP_TAKEN(skip),
    .O_Q_PHASE(q_phase), .O_CYCLE_START(cyc_start), .O_VALID(vld),
    .O_NOP(nop_o), .O_CLASS(cls), .O_OPCODE(opc), .O_FIELDS(fld),
    .O_DOUBLE(dbl), .O_SKIP_TYPE(skt), .O_CYCLES(cycles));
  // Load a program, fetch it and capture each published decode
  task automatic run_prog(input logic [15:0] w [$], input int n,
                          input int skip_at);
    int k;
    k = 0;
    foreach (w[i]) iwd_prog_mem_inst.mem[i] = w[i];
    @(posedge clk);
    run <= 1'b1;
    for (int i = 0; i < 100 && k < n; i++) begin
      @(posedge clk);
      skip <= (k == skip_at);
      #1;
      if (vld === 1'b1) begin
        cap[k] = '{nop_o, cls, fld, dbl, skt, cycles, cyc_start};
        k++;
      end
    end
    @(posedge clk);
    run <= 1'b0;
    skip <= 1'b0;
    `IWD_CHK(k, n, "decode count")
  endtask : run_prog
  task automatic sc_byte_bit;
    run_prog('{16'h2735, 16'h2435, 16'h8B35, 16'h8E35, 16'h2E35,
               16'hA235}, 6, -1);
    `IWD_CHK(cap[0].cls, iwd_pkg::IWD_BYTE, "byte group")
    `IWD_CHK(cap[0].f.dest_file, 1'b1, "dest file")
    `IWD_CHK(cap[1].f.dest_file, 1'b0, "dest working")
    `IWD_CHK(cap[0].f.bank_from_sel, 1'b1, "bank sel")
    `IWD_CHK(cap[1].f.bank_from_sel, 1'b0, "access bank")
    `IWD_CHK(cap[0].f.file_addr[7:0], 8'h35, "file addr")
    `IWD_CHK(cap[2].cls, iwd_pkg::IWD_BIT, "bit group")
    `IWD_CHK(cap[2].f.bit_num, 3'h5, "bit five")
    `IWD_CHK(cap[3].f.bit_num, 3'h7, "bit seven")
    `IWD_CHK(cap[0].skt, 1'b0, "plain byte")
    `IWD_CHK(cap[2].skt, 1'b0, "plain bit")
    `IWD_CHK(cap[4].skt, 1'b1, "byte skip")
    `IWD_CHK(cap[4].cyc, 2'h1, "skip base cycle")
    `IWD_CHK(cap[5].skt, 1'b1, "bit skip")
  endtask : sc_byte_bit
  task automatic sc_literal;
    run_prog('{16'h0E7F, 16'hEE1A, 16'hF0BC, 16'hD005, 16'hE005}, 4, -1);
    `IWD_CHK(cap[0].cls, iwd_pkg::IWD_LITERAL, "lit group")
    `IWD_CHK(cap[0].f.literal, 20'h0_007F, "lit value")
    `IWD_CHK(cap[0].cyc, 2'h1, "lit cycles")
    `IWD_CHK(cap[0].cs, 1'b1, "cycle start")
    `IWD_CHK(cap[1].f.literal, 20'h0_0ABC, "ptr value")
    `IWD_CHK(cap[1].f.ptr_sel, 2'h1, "ptr select")
    `IWD_CHK(cap[1].cyc, 2'h2, "ptr cycles")
    `IWD_CHK(cap[2].cls, iwd_pkg::IWD_CONTROL, "jump group")
    `IWD_CHK(cap[2].cyc, 2'h2, "jump cycles")
    `IWD_CHK(cap[3].skt, 1'b1, "cond branch")
  endtask : sc_literal
  task automatic sc_control;
    run_prog('{16'hEF12, 16'hF345, 16'hED56, 16'hF001, 16'hC123,
               16'hF456}, 3, -1);
    `IWD_CHK(cap[0].f.literal, 20'h3_4512, "goto addr")
    `IWD_CHK(cap[0].dbl, 1'b1, "goto double")
    `IWD_CHK(cap[0].cyc, 2'h2, "goto cycles")
    `IWD_CHK(cap[1].f.fast, 1'b1, "call fast")
    `IWD_CHK(cap[1].f.literal, 20'h0_0156, "call addr")
    `IWD_CHK(cap[2].f.file_addr, 12'h123, "move source")
    `IWD_CHK(cap[2].f.file_dst, 12'h456, "move dest")
    run_prog('{16'h0008, 16'h0009, 16'h000A, 16'h000B, 16'h0013,
               16'h0012}, 6, -1);
    for (int m = 0; m < 4; m++) begin
      `IWD_CHK(cap[m].f.tbl_mode, m[1:0], "table mode")
    end
    `IWD_CHK(cap[4].cls, iwd_pkg::IWD_CONTROL, "return group")
    `IWD_CHK(cap[4].f.fast, 1'b1, "return fast")
    `IWD_CHK(cap[5].f.fast, 1'b0, "return plain")
  endtask : sc_control
  task automatic sc_stray_skip;
    run_prog('{16'hF123, 16'h0E11, 16'h0E22, 16'h0E33}, 4, 1);
    `IWD_CHK(cap[0].nop, 1'b1, "stray word")
    `IWD_CHK(cap[1].nop, 1'b0, "skip owner runs")
    `IWD_CHK(cap[2].nop, 1'b1, "squashed word")
    `IWD_CHK(cap[3].nop, 1'b0, "after squash")
    `IWD_CHK(cap[3].f.literal, 20'h0_0033, "after value")
  endtask : sc_stray_skip
  // Verdict and end of run
  task automatic end_sim;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // Hang guard
  always @(posedge clk) begin
    cyc_count++;
    if (cyc_count == 5000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    sc_byte_bit();
    sc_literal();
    sc_control();
    sc_stray_skip();
    end_sim();
  end
endmodule : instruction_word_decode_timing_tb_top
